// >>> hw/ubr_uart.sv
// break transmitter and oversampled receiver with two-word buffer, apb registers
//
// Function
// - break bit sends break on next frame
// - start, then 13xN low bits, then stop_count_sel
// - break bit held gives continuous breaks
// - after clear, finish break, send stop_count_sel
// - break sending raises no transmit interrupt
// - 8 or 9 bit words, ninth kept
// - recovery at 16x, shift per bit
// - bit level by three-sample majority
// - after stop sample, word into buffer
// - serial data enters lsb first
// - two-deep buffer, third word overruns
// - receiver enable starts start-bit hunting
// - available flag while buffer not empty
// - irq on load or overrun if enabled
// - status access then data read clears
// - break gives framing error, zero data
// - after break, wait for high level
// - idle low from start to stop
// - framing, noise, parity, overrun flags kept
// - only first stop bit is checked
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module ubr_uart
    import ubr_pkg::*;
(
    input  wire logic        sys_clk,   // 20 MHz clock
    input  wire logic        reset,     // async reset, active high
    input  wire logic        psel,      // apb select
    input  wire logic        penable,   // apb access phase
    input  wire logic        pwrite,    // apb write
    input  wire logic [7:0]  paddr,     // apb byte address
    input  wire logic [31:0] pwdata,    // apb write data
    output logic      [31:0] prdata,    // apb read data
    output logic             pready,    // apb ready
    output logic             pslverr,   // apb error, unmapped address
    input  wire logic        rx_pin,    // serial input
    output logic             tx_pin,    // serial output
    output logic             rx_irq     // receive irq, one-cycle pulse
);
    // control and baud registers
    logic [6:0]    ctrl_reg;
    logic [15:0]   baud_divisor;
    logic [15:0]   baud_cnt_reg;
    logic          os_tick;
    // apb
    logic          pready_reg;
    logic [31:0]   prdata_reg;
    logic          pslverr_reg;
    logic          acc_start;
    logic          acc_done;
    logic          hit_ctrl;
    logic          hit_status;
    logic          hit_data;
    logic          hit_baud;
    logic          mapped;
    logic [31:0]   rd_value;
    logic          status_seen_reg;
    logic          pop;
    // receiver
    logic          rx_meta_reg;
    logic          rx_sync_reg;
    ubr_rx_state_t rx_state_reg;
    logic [3:0]    rx_phase_reg;
    logic [3:0]    rx_bitcnt_reg;
    logic [1:0]    rx_samp_reg;
    logic [8:0]    rx_shift_reg;
    logic          rx_noise_reg;
    logic          rx_idle_flag;
    logic          rx_bit;
    logic          rx_noisy;
    logic          decide;
    logic [3:0]    word_bits;
    logic [8:0]    rx_word;
    logic          rx_par_bad;
    logic          stop_done;
    // buffer
    logic [11:0]   buf_mem [2];
    logic          wr_ptr_reg;
    logic          rd_ptr_reg;
    logic [1:0]    count_reg;
    logic          buf_full;
    logic          push;
    logic          overrun_flag;
    logic          rx_avail_flag;
    logic [11:0]   head;
    logic          irq_reg;
    // transmitter
    ubr_tx_state_t tx_state_reg;
    logic [3:0]    tx_phase_reg;
    logic [3:0]    tx_bitcnt_reg;
    logic          tx_reg;
    logic          tx_bit_end;

    function automatic logic majority(input logic [2:0] s);
        majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign tx_pin  = tx_reg;
    assign rx_irq  = irq_reg;

    // 16x oversampling tick from baud divisor
    assign os_tick = (baud_cnt_reg >= baud_divisor);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            baud_cnt_reg <= 16'h0000;
        end else if (os_tick) begin
            baud_cnt_reg <= 16'h0000;
        end else begin
            baud_cnt_reg <= baud_cnt_reg + 16'h0001;
        end
    end

    // apb decode, one wait state per access
    assign acc_start  = psel & penable & ~pready_reg;
    assign acc_done   = psel & penable & pready_reg;
    assign hit_ctrl   = (paddr == ADDR_CTRL);
    assign hit_status = (paddr == ADDR_STATUS);
    assign hit_data   = (paddr == ADDR_DATA);
    assign hit_baud   = (paddr == ADDR_BAUD);
    assign mapped     = hit_ctrl | hit_status | hit_data | hit_baud;
    assign pop        = acc_done & ~pwrite & hit_data & status_seen_reg & rx_avail_flag;

    always_comb begin
        rd_value = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_value[6:0]       = ctrl_reg;
            rd_value[CTL_NINTH] = head[8];
        end else if (hit_status) begin
            rd_value[ST_AVAIL]   = rx_avail_flag;
            rd_value[ST_OVERRUN] = overrun_flag;
            rd_value[ST_FRAME]   = rx_avail_flag & head[9];
            rd_value[ST_PARITY]  = rx_avail_flag & head[10];
            rd_value[ST_NOISE]   = rx_avail_flag & head[11];
            rd_value[ST_RX_IDLE] = rx_idle_flag;
            rd_value[ST_TX_IDLE] = (tx_state_reg == TX_IDLE);
        end else if (hit_data) begin
            rd_value[8:0] = head[8:0];
        end else if (hit_baud) begin
            rd_value[15:0] = baud_divisor;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= acc_start;
            prdata_reg  <= acc_start & ~pwrite ? rd_value : 32'h0000_0000;
            pslverr_reg <= acc_start & ~mapped;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg     <= CTRL_RESET;
            baud_divisor <= BAUD_RESET;
        end else if (acc_done & pwrite & hit_ctrl) begin
            ctrl_reg <= pwdata[6:0];
        end else if (acc_done & pwrite & hit_baud) begin
            baud_divisor <= pwdata[15:0];
        end
    end

    // status access arms the clearing data read
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            status_seen_reg <= 1'b0;
        end else if (acc_done & ~pwrite & hit_status) begin
            status_seen_reg <= 1'b1;
        end else if (acc_done & hit_data) begin
            status_seen_reg <= 1'b0;
        end
    end

    // receive input synchroniser
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= rx_pin;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // bit decision after third sample
    assign decide     = os_tick & (rx_phase_reg == SAMPLE_C);
    assign rx_bit     = majority({rx_samp_reg[1:0], rx_sync_reg});
    assign rx_noisy   = ~(&{rx_samp_reg[1:0], rx_sync_reg}) & (|{rx_samp_reg[1:0], rx_sync_reg});
    assign word_bits  = ctrl_reg[CTL_NINE] ? BITS_NINE : BITS_EIGHT;
    assign rx_word    = ctrl_reg[CTL_NINE] ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
    assign rx_par_bad = ctrl_reg[CTL_PAR_ON] & ((^rx_word) ^ ctrl_reg[CTL_PAR_ODD]);
    assign stop_done  = decide & (rx_state_reg == RX_STOP) & ctrl_reg[CTL_RX_ON];
    assign buf_full   = count_reg[1];
    assign push       = stop_done & ~buf_full;
    assign rx_avail_flag = (count_reg != 2'b00);
    assign head       = buf_mem[rd_ptr_reg];

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_state_reg  <= RX_OFF;
            rx_phase_reg  <= 4'h0;
            rx_bitcnt_reg <= 4'h0;
            rx_samp_reg   <= 2'h3;
            rx_shift_reg  <= 9'h000;
            rx_noise_reg  <= 1'b0;
            rx_idle_flag  <= 1'b1;
        end else if (~ctrl_reg[CTL_RX_ON]) begin
            rx_state_reg <= RX_OFF;
            rx_idle_flag <= 1'b1;
        end else if (os_tick) begin
            rx_phase_reg <= rx_phase_reg + 4'h1;
            rx_samp_reg  <= {rx_samp_reg[0], rx_sync_reg};
            case (rx_state_reg)
                RX_OFF: begin
                    rx_state_reg <= RX_WAITH;
                end
                RX_WAITH: begin
                    if (rx_sync_reg) begin
                        rx_state_reg <= RX_HUNT;
                    end
                end
                RX_HUNT: begin
                    if (~rx_sync_reg) begin
                        rx_state_reg <= RX_START;
                        rx_phase_reg <= 4'h1;
                        rx_idle_flag <= 1'b0;
                        rx_noise_reg <= 1'b0;
                    end
                end
                RX_START: begin
                    if (rx_phase_reg == SAMPLE_C) begin
                        if (rx_bit) begin
                            rx_state_reg <= RX_HUNT;
                            rx_idle_flag <= 1'b1;
                        end else begin
                            rx_noise_reg <= rx_noisy;
                        end
                    end else if (rx_phase_reg == OVS_LAST) begin
                        rx_state_reg  <= RX_DATA;
                        rx_bitcnt_reg <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (rx_phase_reg == SAMPLE_C) begin
                        rx_shift_reg  <= {rx_bit, rx_shift_reg[8:1]};
                        rx_noise_reg  <= rx_noise_reg | rx_noisy;
                        rx_bitcnt_reg <= rx_bitcnt_reg + 4'h1;
                    end else if (rx_phase_reg == OVS_LAST && rx_bitcnt_reg == word_bits) begin
                        rx_state_reg <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_phase_reg == SAMPLE_C) begin
                        rx_idle_flag <= 1'b1;
                        rx_state_reg <= rx_bit ? RX_HUNT : RX_WAITH;
                    end
                end
                default: begin
                    rx_state_reg <= RX_OFF;
                end
            endcase
        end
    end

    // two-word receive buffer: {noise, parity, frame, data}
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            buf_mem[0] <= 12'h000;
            buf_mem[1] <= 12'h000;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'b00;
        end else begin
            if (push) begin
                // a break arrives as zero data with the frame bit set
                buf_mem[wr_ptr_reg] <= {rx_noise_reg | rx_noisy, rx_par_bad, ~rx_bit,
                                        rx_word};
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 2'b01;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 2'b01;
            end
        end
    end

    // overrun and receive irq; set wins over clear
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            overrun_flag <= 1'b0;
            irq_reg      <= 1'b0;
        end else begin
            if (stop_done & buf_full) begin
                overrun_flag <= 1'b1;
            end else if (pop) begin
                overrun_flag <= 1'b0;
            end
            irq_reg <= stop_done & ctrl_reg[CTL_IRQ_EN];
        end
    end

    // break transmitter, bit time is sixteen oversampling ticks
    assign tx_bit_end = os_tick & (tx_phase_reg == OVS_LAST);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_state_reg  <= TX_IDLE;
            tx_phase_reg  <= 4'h0;
            tx_bitcnt_reg <= 4'h0;
            tx_reg        <= 1'b1;
        end else begin
            if (os_tick) begin
                tx_phase_reg <= tx_phase_reg + 4'h1;
            end
            case (tx_state_reg)
                TX_IDLE: begin
                    tx_reg <= 1'b1;
                    if (tx_bit_end & ctrl_reg[CTL_BRK]) begin
                        tx_state_reg <= TX_START;
                        tx_reg       <= 1'b0;
                    end
                end
                TX_START: begin
                    if (tx_bit_end) begin
                        tx_state_reg  <= TX_LOW;
                        tx_bitcnt_reg <= 4'h1;
                    end
                end
                TX_LOW: begin
                    if (tx_bit_end) begin
                        if (tx_bitcnt_reg != BRK_BITS) begin
                            tx_bitcnt_reg <= tx_bitcnt_reg + 4'h1;
                        end else if (ctrl_reg[CTL_BRK]) begin
                            tx_bitcnt_reg <= 4'h1;
                        end else begin
                            tx_state_reg  <= TX_STOP;
                            tx_bitcnt_reg <= 4'h1;
                            tx_reg        <= 1'b1;
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_bit_end) begin
                        if (ctrl_reg[CTL_STOP2] && tx_bitcnt_reg == 4'h1) begin
                            tx_bitcnt_reg <= 4'h2;
                        end else begin
                            tx_state_reg <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state_reg <= TX_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> hw/ubr_pkg.sv
// shared constants and types for the break transmitter and receiver
package ubr_pkg;
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_STATUS     = 8'h04;
    localparam logic [7:0]  ADDR_DATA       = 8'h08;
    localparam logic [7:0]  ADDR_BAUD       = 8'h0C;
    // control register fields
    localparam int          CTL_BRK         = 0;
    localparam int          CTL_NINE        = 1;
    localparam int          CTL_PAR_ON      = 2;
    localparam int          CTL_PAR_ODD     = 3;
    localparam int          CTL_STOP2       = 4;
    localparam int          CTL_RX_ON       = 5;
    localparam int          CTL_IRQ_EN      = 6;
    localparam int          CTL_NINTH       = 7;
    localparam logic [6:0]  CTRL_RESET      = 7'h00;
    // status register fields
    localparam int          ST_AVAIL        = 0;
    localparam int          ST_OVERRUN      = 1;
    localparam int          ST_FRAME        = 2;
    localparam int          ST_NOISE        = 3;
    localparam int          ST_PARITY       = 4;
    localparam int          ST_RX_IDLE      = 5;
    localparam int          ST_TX_IDLE      = 6;
    localparam logic [15:0] BAUD_RESET      = 16'h0009;
    // timing counts
    localparam logic [3:0]  OVS_LAST        = 4'hF;
    localparam logic [3:0]  SAMPLE_A        = 4'h7;
    localparam logic [3:0]  SAMPLE_B        = 4'h8;
    localparam logic [3:0]  SAMPLE_C        = 4'h9;
    localparam logic [3:0]  BRK_BITS        = 4'hD;
    localparam logic [3:0]  BITS_EIGHT      = 4'h8;
    localparam logic [3:0]  BITS_NINE       = 4'h9;

    typedef enum logic [2:0] {
        RX_OFF   = 3'b000,
        RX_WAITH = 3'b001,
        RX_HUNT  = 3'b010,
        RX_START = 3'b011,
        RX_DATA  = 3'b100,
        RX_STOP  = 3'b101
    } ubr_rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_START = 2'b01,
        TX_LOW   = 2'b10,
        TX_STOP  = 2'b11
    } ubr_tx_state_t;
endpackage

// >>> bench/ubr_uart_chk.sv
// port assertions for the break transmitter and receiver
`timescale 1ns/1ns
module ubr_uart_chk
    import ubr_pkg::*;
(
    input wire logic        sys_clk, // clock
    input wire logic        reset,   // async reset
    input wire logic        psel,    // apb select
    input wire logic        penable, // apb access
    input wire logic        pwrite,  // apb write
    input wire logic [7:0]  paddr,   // apb address
    input wire logic [31:0] pwdata,  // apb write data
    input wire logic [31:0] prdata,  // apb read data
    input wire logic        pready,  // apb ready
    input wire logic        pslverr, // apb error
    input wire logic        rx_pin,  // serial in
    input wire logic        tx_pin,  // serial out
    input wire logic        rx_irq   // receive irq
);
    logic [31:0] ctl_m;
    logic [15:0] baud_m;
    int          txl;
    int          txh;
    int          rxl;
    int          bc;
    wire         wr_done = psel && penable && pready && pwrite;
    // clocks per bit from the mirrored divisor
    assign bc = 16 * (int'(baud_m) + 1);
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctl_m  <= 32'h0;
            baud_m <= BAUD_RESET;
            txl    <= 0;
            txh    <= 1000000;
            rxl    <= 0;
        end else begin
            if (wr_done && paddr == ADDR_CTRL)
                ctl_m <= pwdata;
            if (wr_done && paddr == ADDR_BAUD)
                baud_m <= pwdata[15:0];
            txl <= tx_pin ? 0 : txl + 1;
            txh <= tx_pin ? txh + 1 : 0;
            rxl <= rx_pin ? 0 : rxl + 1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_req;
        psel && penable && !pready;
    endsequence
    sequence s_bad;
        s_req ##0 (paddr > ADDR_BAUD);
    endsequence
    property p_wait; s_req |=> pready; endproperty
    property p_one; pready |=> !pready; endproperty
    property p_err; s_bad |=> pready && pslverr; endproperty
    property p_irq_pulse; rx_irq |=> !rx_irq; endproperty
    property p_irq_en; rx_irq |-> $past(ctl_m[CTL_IRQ_EN] && ctl_m[CTL_RX_ON]); endproperty
    property p_brk_len; $rose(tx_pin) |-> txl % bc == 0 && (txl / bc) % 13 == 1; endproperty
    property p_stop; $fell(tx_pin) |-> txh >= bc * (1 + int'(ctl_m[CTL_STOP2])); endproperty
    property p_fall; $fell(tx_pin) |-> $past(ctl_m[CTL_BRK]); endproperty
    property p_brk_once; rx_irq |-> rxl < 11 * bc + 8; endproperty
    a_wait: assert property (p_wait) else $error("ready missing after access");
    a_one: assert property (p_one) else $error("ready longer than one cycle");
    a_err: assert property (p_err) else $error("unmapped access without error");
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");
    a_irq_en: assert property (p_irq_en) else $error("irq while masked or off");
    a_brk_len: assert property (p_brk_len) else $error("break low length wrong");
    a_stop: assert property (p_stop) else $error("stop time after break short");
    a_fall: assert property (p_fall) else $error("tx low without break request");
    a_brk_once: assert property (p_brk_once) else $error("break taken as start");
endmodule
bind ubr_uart ubr_uart_chk u_ubr_uart_chk (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .rx_irq(rx_irq)
);

// >>> bench/ubr_peer.sv
// remote serial device: drives the receive line, watches the transmit line
`timescale 1ns/1ns
module ubr_peer #(
    parameter int BIT = 16
) (
    input  wire logic sys_clk, // bench clock
    input  wire logic tx_pin,  // line from the block
    output logic      rx_line  // line into the block
);
    int tx_low;
    initial begin
        rx_line = 1'b1;
        tx_low  = 0;
    end
    always @(posedge sys_clk)
        if (tx_pin === 1'b0)
            tx_low++;
    task automatic level(input logic v, input int n);
        rx_line <= v;
        repeat (n) @(posedge sys_clk);
    endtask
    // start, word lsb first, one stop level, then idle high
    task automatic frame(input logic [8:0] d, input int nb, input logic stp);
        level(1'b0, BIT);
        for (int i = 0; i < nb; i++)
            level(d[i], BIT);
        level(stp, BIT);
        level(1'b1, 2 * BIT);
    endtask
endmodule

// >>> bench/uart_break_tx_and_receiver_tb_top.sv
// testbench: registers, received frames, break receive and send
`timescale 1ns/1ns
module uart_break_tx_and_receiver_tb_top
    import ubr_pkg::*;
;
    logic        sys_clk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         rx_pin;
    wire         tx_pin;
    wire         rx_irq;
    int          errors;
    int          tests_run;
    int          cyc;
    int          irqs;
    int          irq_exp;
    logic [64:0] notes[$];
    logic [8:0]  w[3];
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    ubr_uart u_ubr_uart (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin), .rx_irq(rx_irq));
    ubr_peer #(.BIT(16)) u_ubr_peer (.sys_clk(sys_clk), .tx_pin(tx_pin), .rx_line(rx_pin));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // result watcher: oldest note against each read answer
    always @(posedge sys_clk) begin
        logic [64:0] n;
        if (rx_irq === 1'b1)
            irqs++;
        if (pready === 1'b1 && psel === 1'b1 && pwrite === 1'b0) begin
            n = notes.pop_front();
            chk("prdata", prdata & n[63:32], n[31:0]);
            chk("pslverr", {31'h0, pslverr}, {31'h0, n[64]});
        end
        cyc++;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [31:0] e, input logic x);
        if (!w)
            notes.push_back({x, m, e & m});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0, m, e, 1'b0);
    endtask
    task automatic st(input logic [31:0] e);
        rd(ADDR_STATUS, 32'h3F, e);
    endtask
    initial begin
        int         r;
        logic [8:0] d;
        r = $urandom(98902);
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        tests_run = 0;
        cyc = 0;
        irqs = 0;
        irq_exp = 0;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(ADDR_CTRL, 32'hFF, 32'h0);
        rd(ADDR_BAUD, 32'hFFFF, 32'h9);
        bus(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
        wr(ADDR_BAUD, 32'h0);
        rd(ADDR_BAUD, 32'hFFFF, 32'h0);
        wr(ADDR_CTRL, 32'h40);
        u_ubr_peer.frame(9'h0A5, 8, 1'b1);
        st(32'h20);
        wr(ADDR_CTRL, 32'h60);
        for (int i = 0; i < 3; i++) begin
            w[i] = 9'($urandom_range(255));
            u_ubr_peer.frame(w[i], 8, 1'b1);
        end
        irq_exp += 3;
        chk("irq", irqs, irq_exp);
        st(32'h23);
        rd(ADDR_DATA, 32'h1FF, 32'(w[0]));
        rd(ADDR_DATA, 32'h1FF, 32'(w[1]));
        st(32'h21);
        rd(ADDR_DATA, 32'h1FF, 32'(w[1]));
        st(32'h20);
        d = 9'($urandom_range(511));
        wr(ADDR_CTRL, 32'h22);
        u_ubr_peer.frame(d, 9, 1'b1);
        rd(ADDR_CTRL, 32'hFF, {24'h0, d[8], 7'h22});
        st(32'h21);
        rd(ADDR_DATA, 32'h1FF, 32'(d));
        chk("irq", irqs, irq_exp);
        for (int p = 0; p < 2; p++)
            for (int e = 0; e < 2; e++) begin
                d[7:0] = 8'($urandom);
                d[8] = ^d[7:0] ^ p[0] ^ e[0];
                wr(ADDR_CTRL, 32'h66 | (p << 3));
                u_ubr_peer.frame(d, 9, 1'b1);
                st(32'h21 | (e << 4));
                rd(ADDR_DATA, 32'h1FF, 32'(d));
            end
        wr(ADDR_CTRL, 32'h70);
        for (int s = 0; s < 2; s++) begin
            d = 9'($urandom_range(255));
            u_ubr_peer.frame(d, 8, s[0]);
            st(32'h21 | ((1 - s) << 2));
            rd(ADDR_DATA, 32'h1FF, 32'(d));
        end
        irq_exp += 6;
        // long break: one zero word, line still low
        u_ubr_peer.level(1'b0, 20 * 16);
        st(32'h25);
        u_ubr_peer.level(1'b0, 10 * 16);
        u_ubr_peer.level(1'b1, 32);
        rd(ADDR_DATA, 32'h1FF, 32'h0);
        st(32'h20);
        irq_exp++;
        u_ubr_peer.level(1'b0, 3);
        u_ubr_peer.level(1'b1, 40);
        st(32'h20);
        chk("irq", irqs, irq_exp);
        // break send held across one 13-bit boundary
        wr(ADDR_CTRL, 32'h11);
        repeat (300) @(posedge sys_clk);
        rd(ADDR_STATUS, 32'h40, 32'h0);
        wr(ADDR_CTRL, 32'h10);
        repeat (200) @(posedge sys_clk);
        chk("tx_low", u_ubr_peer.tx_low, 16 * 27);
        chk("tx_pin", {31'h0, tx_pin}, 32'h1);
        rd(ADDR_STATUS, 32'h40, 32'h40);
        // short break cleared before its first boundary
        wr(ADDR_CTRL, 32'h11);
        repeat (40) @(posedge sys_clk);
        wr(ADDR_CTRL, 32'h10);
        repeat (300) @(posedge sys_clk);
        chk("tx_low", u_ubr_peer.tx_low, 16 * 41);
        chk("tx_pin", {31'h0, tx_pin}, 32'h1);
        chk("irq", irqs, irq_exp);
        summarize();
    end
endmodule
